/* File: verilog/mpsi_top.sv */
// mac physical-side interface: transmit fifo, pin capture, management and alignment logic
// Overview of operation
// R1: drive management data only while tristate low
// R2: host present: management clock divided from system
// R3: host absent: external clock serves sublayer registers
// R4: integrator ties management data input high
// R5: transmit clocks derived from 125 MHz reference
// R6: byte mode sends data, enable, error
// R7: byte mode samples receive on recovered clock
// R8: ten-bit mode sends code group, forwarded clock
// R9: lock-to-reference output always low
// R10: wrap output follows control bit 14
// R11: two receive symbol inputs, own clocks
// R12: comma enable while synchronisation is lost
// R13: asynchronous address selects sublayer registers
// R14: signal detect high means light present
// R15: integrator ties signal detect high if unused
// R16: transceiver reset until clock generator locked
// R17: integrator supplies both transceiver user clocks
// R18: reference select picks primary or alternate
// R19: asynchronous inputs pass synchroniser stages
// R20: management frames follow clause-22 format
`timescale 1ns/1ps

module mpsi_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // pointers carry one extra bit so full and empty differ
    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q[AW-1:0]];

    // storage has no reset, only the pointers matter
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module mpsi_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // configuration
    input wire logic [1:0] phy_mode,
    input wire logic host_port_present,
    input wire logic [mpsi_pkg::MDC_DIV_W-1:0] mdc_divide,
    // host management commands
    input wire logic mgmt_req,
    input wire logic [1:0] mgmt_op,
    input wire logic [4:0] mgmt_phy_addr,
    input wire logic [4:0] mgmt_reg_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic mgmt_ready,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rdata_valid,
    // management pins
    output logic mdc,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_tri,
    // client transmit
    input wire logic [mpsi_pkg::TX_WORD_W-1:0] tx_data,
    input wire logic tx_error,
    input wire logic tx_valid,
    output logic tx_ready,
    // byte-wide phy pins
    input wire logic tx_ref_clock_125,
    output logic phy_tx_clock,
    output logic [7:0] phy_tx_data,
    output logic phy_tx_enable,
    output logic phy_tx_error,
    input wire logic phy_rx_clock,
    input wire logic [7:0] phy_rx_data,
    input wire logic phy_rx_valid,
    input wire logic phy_rx_error,
    input wire logic phy_carrier_sense,
    input wire logic phy_collision,
    // client receive, byte mode
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_error,
    output logic rx_strobe,
    output logic carrier_sense,
    output logic collision,
    // ten-bit serdes pins
    output logic [9:0] serdes_tx_symbol,
    output logic serdes_tx_clock,
    output logic serdes_lock_to_ref,
    output logic serdes_wrap,
    input wire logic [9:0] serdes_rx_symbol_even,
    input wire logic [9:0] serdes_rx_symbol_odd,
    input wire logic serdes_rx_clock_even,
    input wire logic serdes_rx_clock_odd,
    output logic comma_align_enable,
    // client receive, ten-bit mode
    output logic [9:0] rx_symbol,
    output logic rx_symbol_odd,
    output logic rx_symbol_strobe,
    output logic link_synced,
    // sublayer address and light detect
    input wire logic [4:0] sublayer_mgmt_address,
    input wire logic signal_detect,
    output logic light_present,
    // integrated transceiver control
    input wire logic clockgen_locked,
    input wire logic xcvr_ref_select,
    output logic xcvr_reset,
    output logic xcvr_use_alternate
);
    import mpsi_pkg::*;

    typedef enum logic [1:0] {MPSI_SYNC_LOSS, MPSI_SYNC_ACQ, MPSI_SYNC_OK} mpsi_sync_t;
    typedef enum logic {MPSI_MST_IDLE, MPSI_MST_RUN} mpsi_mst_t;
    typedef enum logic [1:0] {MPSI_SL_HUNT, MPSI_SL_HDR, MPSI_SL_TA, MPSI_SL_DATA} mpsi_sl_t;

    function automatic logic is_comma(input logic [9:0] sym);
        return (sym[6:0] == COMMA_PLUS) || (sym[6:0] == COMMA_MINUS);
    endfunction

    logic [ASYNC_W-1:0] pins, s1_q, s2_q, s3_q, st_q, prev_q, rise;
    logic [MDC_DIV_W-1:0] div_q;
    logic mdc_q, mdc_rise, mdc_fall, sl_rise, sl_in, mst_in, tx_tick;
    logic fifo_valid, fifo_pop;
    logic [TX_WORD_W-1:0] fifo_word, push_word;
    mpsi_sync_t sync_q;
    logic [1:0] comma_q;
    mpsi_mst_t mst_q;
    logic [63:0] mst_sh_q;
    logic [6:0] mst_n_q;
    logic mst_rd_q, mst_out_q, mst_tri_q;
    mpsi_sl_t sl_q;
    logic [5:0] ones_q;
    logic [3:0] sl_n_q;
    logic [12:0] hdr_q;
    logic [13:0] hdr_full;
    logic [4:0] sl_reg_q;
    logic sl_rd_q, sl_drive_q, sl_out_q;
    logic [15:0] sl_sh_q, ctrl0_q, status_w, rd_word;

    assign pins = {serdes_rx_symbol_odd, serdes_rx_symbol_even, phy_rx_data, sublayer_mgmt_address,
                   serdes_rx_clock_odd, serdes_rx_clock_even, phy_collision, phy_carrier_sense,
                   phy_rx_error, phy_rx_valid, phy_rx_clock, tx_ref_clock_125, xcvr_ref_select,
                   clockgen_locked, signal_detect, mdio_in, mdc_in};

    // three stages; a bit moves on only once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            st_q <= '0;
            prev_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= (s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q)); // see R19 see R13
            prev_q <= st_q;
        end
    end
    assign rise = st_q & ~prev_q;
    assign light_present = st_q[AI_SIGDET]; // see R14

    // mdc divider: the line toggles every mdc_divide+1 system cycles
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
            mdc_q <= 1'b0;
        end else if (!host_port_present) begin
            div_q <= '0;
            mdc_q <= 1'b0;
        end else if (div_q == mdc_divide) begin
            div_q <= '0;
            mdc_q <= ~mdc_q; // see R2
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign mdc_rise = host_port_present && (div_q == mdc_divide) && !mdc_q;
    assign mdc_fall = host_port_present && (div_q == mdc_divide) && mdc_q;
    assign mdc = mdc_q;

    // host absent: sublayer listens to the external clock and line instead
    assign sl_rise = host_port_present ? mdc_rise : rise[AI_MDC]; // see R3
    assign sl_in = host_port_present ? mst_out_q : st_q[AI_MDIO];
    assign mst_in = sl_drive_q ? sl_out_q : st_q[AI_MDIO];
    assign mdio_out = host_port_present ? mst_out_q : sl_out_q;
    assign mdio_tri = host_port_present ? mst_tri_q : !sl_drive_q; // see R1
    assign mgmt_ready = host_port_present && (mst_q == MPSI_MST_IDLE);

    // master: bits change after the falling mdc edge, read data sampled on the rising edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mst_q <= MPSI_MST_IDLE;
            mst_sh_q <= '0;
            mst_n_q <= '0;
            mst_rd_q <= 1'b0;
            mst_out_q <= 1'b1;
            mst_tri_q <= 1'b1;
            mgmt_rdata <= '0;
            mgmt_rdata_valid <= 1'b0;
        end else begin
            mgmt_rdata_valid <= 1'b0;
            if (mst_q == MPSI_MST_IDLE) begin
                if (mgmt_req && mgmt_ready) begin
                    mst_q <= MPSI_MST_RUN;
                    mst_rd_q <= mgmt_op == MGMT_OP_READ;
                    mst_n_q <= '0;
                    mst_sh_q <= {MGMT_PREAMBLE, MGMT_START, mgmt_op, mgmt_phy_addr, mgmt_reg_addr, // see R20
                                 (mgmt_op == MGMT_OP_READ) ? MGMT_TA_READ : MGMT_TA_WRITE,
                                 (mgmt_op == MGMT_OP_READ) ? 16'hFFFF : mgmt_wdata};
                end
            end else if (mdc_fall) begin
                if (mst_n_q == MGMT_FRAME_BITS) begin
                    mst_q <= MPSI_MST_IDLE;
                    mst_tri_q <= 1'b1;
                    mst_out_q <= 1'b1;
                    mgmt_rdata_valid <= mst_rd_q;
                end else begin
                    mst_out_q <= mst_sh_q[63];
                    mst_sh_q <= {mst_sh_q[62:0], 1'b1};
                    mst_tri_q <= mst_rd_q && (mst_n_q >= MGMT_RD_DRIVE_BITS);
                    mst_n_q <= mst_n_q + 1'b1;
                end
            end else if (mdc_rise && mst_rd_q && (mst_n_q >= MGMT_RD_SAMPLE_FROM)) begin
                mgmt_rdata <= {mgmt_rdata[14:0], mst_in};
            end
        end
    end

    // sublayer register slave, answers only its own synchronised address
    assign hdr_full = {hdr_q, sl_in};
    assign status_w = 16'(({15'h0, link_synced} << STATUS_LINK_BIT) | ({15'h0, light_present} << STATUS_LIGHT_BIT));
    assign rd_word = (sl_reg_q == REG_CTRL0) ? ctrl0_q : ((sl_reg_q == REG_STATUS) ? status_w : 16'h0000);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sl_q <= MPSI_SL_HUNT;
            ones_q <= '0;
            sl_n_q <= '0;
            hdr_q <= '0;
            sl_reg_q <= '0;
            sl_rd_q <= 1'b0;
            sl_drive_q <= 1'b0;
            sl_out_q <= 1'b1;
            sl_sh_q <= '0;
            ctrl0_q <= CTRL0_RESET;
        end else if (sl_rise) begin
            unique case (sl_q)
                MPSI_SL_HUNT: begin
                    if (sl_in) begin
                        ones_q <= (ones_q == MGMT_PREAMBLE_MIN) ? ones_q : ones_q + 1'b1;
                    end else if (ones_q == MGMT_PREAMBLE_MIN) begin
                        sl_q <= MPSI_SL_HDR;
                        hdr_q <= '0;
                        sl_n_q <= 4'h1;
                    end else begin
                        ones_q <= '0;
                    end
                end
                MPSI_SL_HDR: begin
                    hdr_q <= hdr_full[12:0];
                    sl_n_q <= sl_n_q + 1'b1;
                    if (sl_n_q == MGMT_HDR_LAST) begin
                        ones_q <= '0;
                        sl_n_q <= '0;
                        sl_reg_q <= hdr_full[4:0];
                        sl_rd_q <= hdr_full[11:10] == MGMT_OP_READ;
                        if (hdr_full[13:12] == MGMT_START && hdr_full[9:5] == st_q[AI_ADDR+:5] && // see R13
                            (hdr_full[11:10] == MGMT_OP_READ || hdr_full[11:10] == MGMT_OP_WRITE)) begin
                            sl_q <= MPSI_SL_TA;
                        end else begin
                            sl_q <= MPSI_SL_HUNT;
                        end
                    end
                end
                MPSI_SL_TA: begin
                    if (sl_n_q == 4'h0) begin
                        sl_n_q <= 4'h1;
                        sl_drive_q <= sl_rd_q;
                        sl_out_q <= !sl_rd_q;
                    end else begin
                        sl_n_q <= '0;
                        sl_q <= MPSI_SL_DATA;
                        sl_out_q <= sl_rd_q ? rd_word[15] : 1'b1;
                        sl_sh_q <= {rd_word[14:0], 1'b0};
                    end
                end
                MPSI_SL_DATA: begin
                    sl_n_q <= sl_n_q + 1'b1;
                    if (sl_rd_q) begin
                        sl_out_q <= (sl_n_q == MGMT_DATA_LAST) ? 1'b1 : sl_sh_q[15];
                        sl_sh_q <= {sl_sh_q[14:0], 1'b0};
                    end else begin
                        sl_sh_q <= {sl_sh_q[14:0], sl_in};
                    end
                    if (sl_n_q == MGMT_DATA_LAST) begin
                        sl_q <= MPSI_SL_HUNT;
                        sl_drive_q <= 1'b0;
                        if (!sl_rd_q && sl_reg_q == REG_CTRL0) begin
                            ctrl0_q <= {sl_sh_q[14:0], sl_in};
                        end
                    end
                end
            endcase
        end
    end
    assign serdes_wrap = ctrl0_q[CTRL0_LOOPBACK_BIT]; // see R10
    assign serdes_lock_to_ref = 1'b0; // see R9

    // transmit fifo; the stall reaches the client through tx_ready
    assign push_word = (phy_mode == MODE_TEN) ? tx_data : TX_WORD_W'({tx_error, tx_data[7:0]});
    assign tx_tick = rise[AI_TXCLK];
    assign fifo_pop = tx_tick && fifo_valid;
    mpsi_fifo #(.WIDTH(TX_WORD_W), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(push_word),
        .out_valid(fifo_valid),
        .out_ready(tx_tick),
        .out_data(fifo_word)
    );

    // one word leaves per reference clock rise; the forwarded clock is the synchronised reference
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phy_tx_clock <= 1'b0;
            serdes_tx_clock <= 1'b0;
            phy_tx_data <= '0;
            phy_tx_enable <= 1'b0;
            phy_tx_error <= 1'b0;
            serdes_tx_symbol <= '0;
        end else begin
            phy_tx_clock <= (phy_mode == MODE_BYTE) && st_q[AI_TXCLK]; // see R5
            serdes_tx_clock <= (phy_mode == MODE_TEN) && st_q[AI_TXCLK]; // see R8
            if (tx_tick && phy_mode == MODE_BYTE) begin
                phy_tx_data <= fifo_pop ? fifo_word[7:0] : 8'h00; // see R6
                phy_tx_enable <= fifo_pop;
                phy_tx_error <= fifo_pop && fifo_word[TX_ERR_BIT];
            end
            if (fifo_pop && phy_mode == MODE_TEN) begin
                serdes_tx_symbol <= fifo_word; // see R8
            end
        end
    end

    // receive capture on the rise of each synchronised receive clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data <= '0;
            rx_valid <= 1'b0;
            rx_error <= 1'b0;
            rx_strobe <= 1'b0;
            carrier_sense <= 1'b0;
            collision <= 1'b0;
            rx_symbol <= '0;
            rx_symbol_odd <= 1'b0;
            rx_symbol_strobe <= 1'b0;
        end else begin
            rx_strobe <= 1'b0;
            rx_symbol_strobe <= 1'b0;
            carrier_sense <= (phy_mode == MODE_BYTE) && st_q[AI_CRS];
            collision <= (phy_mode == MODE_BYTE) && st_q[AI_COL];
            if (phy_mode == MODE_BYTE && rise[AI_RXCLK]) begin
                rx_data <= st_q[AI_RXD+:8]; // see R7
                rx_valid <= st_q[AI_DV];
                rx_error <= st_q[AI_ER];
                rx_strobe <= 1'b1;
            end
            // the two clocks are half a period apart; even wins a shared cycle
            if (phy_mode == MODE_TEN && (rise[AI_CLKE] || rise[AI_CLKO])) begin
                rx_symbol <= rise[AI_CLKE] ? st_q[AI_SYME+:10] : st_q[AI_SYMO+:10]; // see R11
                rx_symbol_odd <= !rise[AI_CLKE];
                rx_symbol_strobe <= 1'b1;
            end
        end
    end

    // alignment: loss of light or leaving ten-bit mode forces loss of sync
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= MPSI_SYNC_LOSS;
            comma_q <= '0;
        end else if (phy_mode != MODE_TEN || !light_present) begin
            sync_q <= MPSI_SYNC_LOSS; // see R14
            comma_q <= '0;
        end else if (rx_symbol_strobe && is_comma(rx_symbol) && sync_q != MPSI_SYNC_OK) begin
            comma_q <= comma_q + 1'b1;
            sync_q <= (comma_q + 1'b1 == COMMAS_TO_SYNC) ? MPSI_SYNC_OK : MPSI_SYNC_ACQ;
        end
    end
    assign comma_align_enable = sync_q == MPSI_SYNC_LOSS; // see R12
    assign link_synced = sync_q == MPSI_SYNC_OK;

    // transceiver held in reset until the clock generator is locked and transceiver mode is selected
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            xcvr_reset <= 1'b1;
            xcvr_use_alternate <= 1'b0;
        end else begin
            xcvr_reset <= !(phy_mode == MODE_XCVR && st_q[AI_LOCKED]); // see R16
            xcvr_use_alternate <= st_q[AI_REFSEL]; // see R18
        end
    end

    a_mdio_release: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R1
        (!host_port_present && !sl_drive_q) |-> mdio_tri) else $error("mdio driven while released");
    a_mdc_quiet_absent: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R2
        (!host_port_present [*2]) |-> !mdc) else $error("mdc toggles without host port");
    a_lock_ref_low: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R9
        !serdes_lock_to_ref) else $error("lock to reference not low");
    a_wrap_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R10
        (sl_rise && sl_q == MPSI_SL_DATA && sl_n_q == MGMT_DATA_LAST && !sl_rd_q && sl_reg_q == REG_CTRL0)
        |=> serdes_wrap == $past(sl_sh_q[CTRL0_LOOPBACK_BIT-1])) else $error("wrap not loaded from control");
    a_comma_on_dark: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
        !light_present |=> comma_align_enable && !link_synced) else $error("comma enable off without light");
    a_xcvr_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R16
        !st_q[AI_LOCKED] |=> xcvr_reset) else $error("transceiver released before lock");
    a_byte_tx: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R6
        (phy_mode == MODE_BYTE && tx_tick && fifo_valid) |=> phy_tx_enable && phy_tx_data == $past(fifo_word[7:0]))
        else $error("byte not forwarded on reference tick");
    a_byte_rx: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R7
        (phy_mode == MODE_BYTE && rise[AI_RXCLK]) |=> rx_strobe ##1 !rx_strobe) else $error("receive strobe wrong");
    a_even_capture: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R11
        (phy_mode == MODE_TEN && rise[AI_CLKE]) |=> rx_symbol == $past(st_q[AI_SYME+:10]) && !rx_symbol_odd)
        else $error("even symbol not captured");
    a_light_follow: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R19
        (s2_q[AI_SIGDET] == s3_q[AI_SIGDET]) |=> light_present == $past(s3_q[AI_SIGDET]))
        else $error("signal detect not settled");
    a_mgmt_busy: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R20
        (mgmt_req && mgmt_ready) |=> !mgmt_ready [*2]) else $error("master accepted overlapping frame");
endmodule

/* File: verilog/mpsi_pkg.sv */
// constants for the mac physical-side interface block
package mpsi_pkg;
    // attachment modes
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_TEN = 2'h1;
    localparam logic [1:0] MODE_XCVR = 2'h2;
    // positions inside the vector of asynchronous pin inputs
    localparam int AI_MDC = 0;
    localparam int AI_MDIO = 1;
    localparam int AI_SIGDET = 2;
    localparam int AI_LOCKED = 3;
    localparam int AI_REFSEL = 4;
    localparam int AI_TXCLK = 5;
    localparam int AI_RXCLK = 6;
    localparam int AI_DV = 7;
    localparam int AI_ER = 8;
    localparam int AI_CRS = 9;
    localparam int AI_COL = 10;
    localparam int AI_CLKE = 11;
    localparam int AI_CLKO = 12;
    localparam int AI_ADDR = 13;
    localparam int AI_RXD = 18;
    localparam int AI_SYME = 26;
    localparam int AI_SYMO = 36;
    localparam int ASYNC_W = 46;
    // management frame layout
    localparam int MDC_DIV_W = 6;
    localparam logic [1:0] MGMT_START = 2'h1;
    localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
    localparam logic [1:0] MGMT_OP_READ = 2'h2;
    localparam logic [1:0] MGMT_TA_WRITE = 2'h2;
    localparam logic [1:0] MGMT_TA_READ = 2'h3;
    localparam logic [31:0] MGMT_PREAMBLE = 32'hFFFF_FFFF;
    localparam logic [6:0] MGMT_FRAME_BITS = 7'h40;
    localparam logic [6:0] MGMT_RD_DRIVE_BITS = 7'h2E;
    localparam logic [6:0] MGMT_RD_SAMPLE_FROM = 7'h31;
    localparam logic [5:0] MGMT_PREAMBLE_MIN = 6'h20;
    localparam logic [3:0] MGMT_HDR_LAST = 4'hD;
    localparam logic [3:0] MGMT_DATA_LAST = 4'hF;
    // sublayer registers
    localparam logic [4:0] REG_CTRL0 = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam int CTRL0_LOOPBACK_BIT = 14;
    localparam logic [15:0] CTRL0_RESET = 16'h0000;
    localparam int STATUS_LIGHT_BIT = 0;
    localparam int STATUS_LINK_BIT = 2;
    // transmit word layout and code-group alignment
    localparam int TX_WORD_W = 10;
    localparam int TX_ERR_BIT = 8;
    localparam int TX_FIFO_DEPTH = 16;
    localparam logic [6:0] COMMA_PLUS = 7'h1F;
    localparam logic [6:0] COMMA_MINUS = 7'h60;
    localparam logic [1:0] COMMAS_TO_SYNC = 2'h3;
endpackage

/* File: bench/mpsi_phy_model.sv */
// far-side phy model: line pull-up, reference and receive clocks
`timescale 1ns/1ps
module mpsi_phy_model (
    // management line
    input wire logic mdio_out,
    input wire logic mdio_tri,
    output logic mdio_in,
    // reference and receive side
    output logic tx_ref_clock_125,
    output logic phy_rx_clock,
    output logic [7:0] phy_rx_data
);
    // released line floats high through the pull-up
    assign mdio_in = mdio_tri ? 1'b1 : mdio_out;
    // slowed reference so every edge survives the synchroniser
    initial begin
        tx_ref_clock_125 = 1'b0;
        forever #200 tx_ref_clock_125 = ~tx_ref_clock_125;
    end
    // byte moves on the falling clock, held around the rise
    initial begin
        {phy_rx_clock, phy_rx_data} = 9'h000;
        forever #400 {phy_rx_clock, phy_rx_data} = {~phy_rx_clock, phy_rx_data + 8'(phy_rx_clock)};
    end
endmodule

/* File: bench/mpsi_top_tb.sv */
// self-checking bench for the physical-side block
`timescale 1ns/1ps
module mpsi_top_tb;
    import mpsi_pkg::*;
    logic sys_clk, rst_b, host_port_present, mgmt_req, mgmt_ready, mgmt_rdata_valid, mdio_in, mdio_out, mdio_tri;
    logic tx_error, tx_valid, tx_ready, tx_ref_clock_125, phy_rx_clock, phy_tx_enable, phy_tx_error, rx_strobe;
    logic serdes_lock_to_ref, serdes_wrap, signal_detect, light_present, clockgen_locked, xcvr_ref_select;
    logic xcvr_reset, xcvr_use_alternate;
    logic [1:0] phy_mode, mgmt_op;
    logic [3:0] rx_ctl;
    logic [4:0] mgmt_phy_addr, mgmt_reg_addr, sublayer_mgmt_address;
    logic [MDC_DIV_W-1:0] mdc_divide;
    logic [7:0] phy_tx_data, phy_rx_data, rx_data;
    logic [8:0] exp_q[$];
    logic [9:0] tx_data;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic [21:0] sym;
    int n_errors, n_tests, seed, i;
    mpsi_top u_dut (.sys_clk, .rst_b, .phy_mode, .host_port_present, .mdc_divide, .mgmt_req, .mgmt_op, .mgmt_phy_addr,
        .mgmt_reg_addr, .mgmt_wdata, .mgmt_ready, .mgmt_rdata, .mgmt_rdata_valid, .mdc(), .mdc_in(1'b0), .mdio_in,
        .mdio_out, .mdio_tri, .tx_data, .tx_error, .tx_valid, .tx_ready, .tx_ref_clock_125, .phy_tx_clock(),
        .phy_tx_data, .phy_tx_enable, .phy_tx_error, .phy_rx_clock, .phy_rx_data, .phy_rx_valid(rx_ctl[0]),
        .phy_rx_error(rx_ctl[1]), .phy_carrier_sense(rx_ctl[2]), .phy_collision(rx_ctl[3]), .rx_data, .rx_valid(),
        .rx_error(), .rx_strobe, .carrier_sense(), .collision(), .serdes_tx_symbol(), .serdes_tx_clock(),
        .serdes_lock_to_ref, .serdes_wrap, .serdes_rx_symbol_even(sym[9:0]), .serdes_rx_symbol_odd(sym[19:10]),
        .serdes_rx_clock_even(sym[20]), .serdes_rx_clock_odd(sym[21]), .comma_align_enable(), .rx_symbol(),
        .rx_symbol_odd(), .rx_symbol_strobe(), .link_synced(), .sublayer_mgmt_address, .signal_detect,
        .light_present, .clockgen_locked, .xcvr_ref_select, .xcvr_reset, .xcvr_use_alternate);
    mpsi_phy_model u_phy (.mdio_out, .mdio_tri, .mdio_in, .tx_ref_clock_125, .phy_rx_clock, .phy_rx_data);
    task automatic chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one management frame; request held until the edge that takes it
    task automatic mg(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd);
        int k;
        {mgmt_op, mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata, mgmt_req} = {op, pa, ra, wd, 1'b1};
        @(posedge sys_clk) #1 mgmt_req = 1'b0;
        for (k = 0; k < 1300 && mgmt_ready !== 1'b1; k++) @(posedge sys_clk) #1;
        if (k == 1300) n_errors++;
        @(posedge sys_clk) #1;
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // watchdog: ample margin over the run
    initial begin
        #800000 n_errors++;
        tally_and_finish();
    end
    // random receive noise keeps the unused capture paths busy
    always @(posedge sys_clk) {sym, rx_ctl} <= #1 26'($random(seed));
    // bytes leave in push order; one tick's output checked before the next
    always @(posedge tx_ref_clock_125) if (phy_tx_enable === 1'b1)
        chk({phy_tx_error, phy_tx_data}, exp_q.pop_front());
    always @(posedge sys_clk) if (rx_strobe === 1'b1) chk(rx_data, phy_rx_data);
    initial begin
        {rst_b, mgmt_req, tx_valid, tx_error, tx_data, clockgen_locked, seed} = {15'h0, 32'd44};
        {host_port_present, mgmt_op, mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata, signal_detect} = {1'b1, 28'h0, 1'b1};
        {phy_mode, mdc_divide, xcvr_ref_select, sym, rx_ctl} = {MODE_XCVR, 6'h07, 27'h0};
        sublayer_mgmt_address = 5'($random(seed));
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge sys_clk) #1;
        chk(xcvr_reset, 1'b1);
        chk(serdes_lock_to_ref, 1'b0);
        {clockgen_locked, xcvr_ref_select} = {1'b1, 1'($random(seed))};
        repeat (8) @(posedge sys_clk) #1;
        chk(xcvr_reset, 1'b0);
        chk(xcvr_use_alternate, xcvr_ref_select);
        for (i = 0; i < 5; i++) begin
            signal_detect = (i == 4) | 1'($random(seed));
            repeat (8) @(posedge sys_clk) #1;
            chk(light_present, signal_detect);
        end
        #1 rst_b = 1'b0;
        phy_mode = MODE_BYTE;
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge sys_clk) #1;
        mg(MGMT_OP_WRITE, sublayer_mgmt_address, REG_CTRL0, 16'h4000);
        chk(serdes_wrap, 1'b1);
        mg(MGMT_OP_READ, sublayer_mgmt_address, REG_CTRL0, 16'h0000);
        chk(mgmt_rdata, 16'h4000);
        mg(MGMT_OP_READ, sublayer_mgmt_address, REG_STATUS, 16'h0000);
        chk(mgmt_rdata, 16'h0001);
        mg(MGMT_OP_READ, sublayer_mgmt_address ^ 5'h01, REG_CTRL0, 16'h0000);
        chk(mgmt_rdata, 16'hFFFF);
        mg(MGMT_OP_WRITE, sublayer_mgmt_address ^ 5'h01, REG_CTRL0, 16'h0000);
        chk(serdes_wrap, 1'b1);
        tx_valid = 1'b1;
        repeat (40) begin
            {tx_error, tx_data} = 11'($random(seed));
            if (tx_ready) exp_q.push_back({tx_error, tx_data[7:0]});
            @(posedge sys_clk) #1;
        end
        chk(tx_ready, 1'b0);
        tx_valid = 1'b0;
        repeat (250) @(posedge sys_clk);
        chk(exp_q.size(), 16'h0000);
        chk(phy_tx_enable, 1'b0);
        {phy_mode, host_port_present} = {MODE_TEN, 1'b0};
        repeat (99) @(posedge sys_clk) #1;
        chk(mgmt_ready, 1'b0);
        chk(mdio_tri, 1'b1);
        tally_and_finish();
    end
endmodule
